//--- hw/pcm_ctrl.sv
// Power and clock mode control registers and derived enables.
// Assumes a byte register port: one-cycle write/read strobes with address.
`timescale 1ns/100ps
module pcm_ctrl
	import pcm_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic [6:0] i_addr,         // Register address
	input  wire logic [7:0] i_wdata,        // Write data
	input  wire logic       i_wr,           // Write strobe
	input  wire logic       i_rd,           // Read strobe
	input  wire logic       i_pll_ready,    // PLL lock, asynchronous
	input  wire logic [7:0] i_sample_div,   // Sample interval divider
	output logic [7:0]      o_rdata,        // Read data
	output logic            o_rvalid,       // Read data valid
	output logic            o_soft_reset,   // Chip-wide register reset
	output logic            o_sleep,        // Sensing suspended
	output logic            o_accel_sample, // Single accel sample pulse
	output logic [2:0]      o_accel_en,     // X,Y,Z accel enables
	output logic [2:0]      o_rate_sense_en,// X,Y,Z rate sense enables
	output logic            o_rate_drive_en,// Rate drive running
	output logic            o_pll_en,       // PLL running
	output logic            o_thermal_en,   // Temperature sensor on
	output logic            o_use_pll,      // Clock mux: PLL selected
	output logic            o_clk_stop,     // Clock stopped
	output logic            o_timing_rst,   // Timing generator reset
	output logic            o_two_wire_en,  // Two-wire target enabled
	output logic            o_spi_only      // Host port SPI only
);
	// ==========================================================
	// Register state
	logic [7:0] prim_q;     // Power control primary
	logic [7:0] axis_q;     // Sensor axis standby
	logic [7:0] port_q;     // Host port select
	logic [1:0] rst_cnt_q;  // Soft reset progress
	logic       rst_busy_q; // Soft reset in progress
	logic [2:0] pll_s_q;    // PLL ready synchroniser
	logic       pll_ok_q;   // Filtered PLL ready
	pcm_state_t st_q;       // Cycle sequencer state
	pcm_state_t st_d;

	// ==========================================================
	// Decode
	wire        wr_prim    = i_wr && (i_addr == PCM_ADDR_PWR_PRIMARY);
	wire        wr_axis    = i_wr && (i_addr == PCM_ADDR_AXIS_STBY);
	wire        wr_port    = i_wr && (i_addr == PCM_ADDR_HOST_PORT);
	wire        rst_req    = wr_prim && i_wdata[PCM_BIT_RESET_REQ];
	wire        sleep_b    = prim_q[PCM_BIT_SLEEP];
	wire        idle_b     = prim_q[PCM_BIT_RATE_IDLE];
	wire [2:0]  code       = prim_q[2:0];
	wire        cyc_on     = prim_q[PCM_BIT_CYCLE] && !sleep_b && !idle_b;
	wire        accel_all_off = &axis_q[5:3];
	wire        pace_tick;
	wire        code_int   = (code == PCM_CLK_INT0) || (code == PCM_CLK_INT6);
	wire        code_stop  = (code == PCM_CLK_STOP);
	wire [7:0]  rd_mux     = (i_addr == PCM_ADDR_PWR_PRIMARY) ? prim_q :
	                         (i_addr == PCM_ADDR_AXIS_STBY)   ? axis_q :
	                         (i_addr == PCM_ADDR_HOST_PORT)   ? port_q : 8'h00;

	// Pacer for cycle mode wakeups
	pcm_pace u_pace (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (cyc_on),
		.i_div   (i_sample_div),
		.o_tick  (pace_tick)
	);

	// ==========================================================
	// Soft reset sequencer: holds reset, then clears request bit
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rst_busy_q <= 1'b0;
			rst_cnt_q  <= 2'h0;
		end else if (rst_req) begin
			rst_busy_q <= 1'b1;
			rst_cnt_q  <= PCM_RESET_HOLD;
		end else if (rst_busy_q) begin
			rst_cnt_q  <= rst_cnt_q - 2'h1;
			rst_busy_q <= (rst_cnt_q != 2'h1); // Self-clear at end
		end
	end

	// ==========================================================
	// Control registers, reserved bits masked off
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || rst_busy_q) begin
			prim_q <= PCM_RST_PRIMARY;
			axis_q <= PCM_RST_AXIS;
			port_q <= PCM_RST_HOST_PORT;
			if (rst_busy_q && i_rst_n) begin
				// A restart in the last hold cycle wins over the self-clear
				prim_q[PCM_BIT_RESET_REQ] <= (rst_cnt_q != 2'h1) || rst_req;
			end
		end else begin
			if (wr_prim) begin
				prim_q <= (i_wdata & PCM_MASK_PRIMARY) |
				          {i_wdata[PCM_BIT_RESET_REQ], 7'h00};
			end
			if (wr_axis) begin
				axis_q <= i_wdata & PCM_MASK_AXIS;
			end
			if (wr_port) begin
				port_q <= i_wdata & PCM_MASK_HOST_PORT;
			end
		end
	end

	// ==========================================================
	// PLL ready: three stages, change accepted when 2nd and 3rd agree
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pll_s_q  <= 3'h0;
			pll_ok_q <= 1'b0;
		end else begin
			pll_s_q <= {pll_s_q[1:0], i_pll_ready};
			if (pll_s_q[1] == pll_s_q[2]) begin
				pll_ok_q <= pll_s_q[2];
			end
		end
	end

	// ==========================================================
	// Cycle sequencer next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			PCM_ST_OFF:  st_d = cyc_on ? PCM_ST_DOZE : PCM_ST_OFF;
			PCM_ST_DOZE: st_d = !cyc_on ? PCM_ST_OFF : (pace_tick ? PCM_ST_WAKE : PCM_ST_DOZE);
			PCM_ST_WAKE: st_d = cyc_on ? PCM_ST_DOZE : PCM_ST_OFF;
			default:     st_d = PCM_ST_OFF;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_q <= PCM_ST_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata         <= 8'h00;
			o_rvalid        <= 1'b0;
			o_soft_reset    <= 1'b0;
			o_sleep         <= 1'b0;
			o_accel_sample  <= 1'b0;
			o_accel_en      <= 3'h7;
			o_rate_sense_en <= 3'h7;
			o_rate_drive_en <= 1'b1;
			o_pll_en        <= 1'b1;
			o_thermal_en    <= 1'b1;
			o_use_pll       <= 1'b0;
			o_clk_stop      <= 1'b0;
			o_timing_rst    <= 1'b0;
			o_two_wire_en   <= 1'b1;
			o_spi_only      <= 1'b0;
		end else begin
			o_rdata         <= i_rd ? rd_mux : 8'h00;
			o_rvalid        <= i_rd;
			o_soft_reset    <= rst_busy_q;
			// Asleep on sleep bit, or between cycle wakeups
			o_sleep         <= sleep_b || (cyc_on && st_d != PCM_ST_WAKE);
			// No sample when every accel axis is in standby
			o_accel_sample  <= (st_d == PCM_ST_WAKE) && !accel_all_off;
			o_accel_en      <= ~{axis_q[5], axis_q[4], axis_q[3]} &
			                   {3{!sleep_b}};
			o_rate_sense_en <= ~axis_q[2:0] & {3{!sleep_b && !idle_b && !cyc_on}};
			o_rate_drive_en <= !sleep_b && !cyc_on;
			o_pll_en        <= !sleep_b && !code_stop;
			o_thermal_en    <= !prim_q[PCM_BIT_THERM_OFF] && !sleep_b;
			o_use_pll       <= !code_int && !code_stop && pll_ok_q;
			o_clk_stop      <= code_stop;
			o_timing_rst    <= code_stop;
			o_two_wire_en   <= !port_q[PCM_BIT_TWO_WIRE];
			o_spi_only      <= port_q[PCM_BIT_TWO_WIRE];
		end
	end

	// ==========================================================
	// Checks
	sequence s_req;
		rst_req;
	endsequence
	sequence s_done;
		##4 !prim_q[PCM_BIT_RESET_REQ] && prim_q[2:0] == 3'h1;
	endsequence

	rst_self_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		s_req |-> s_done) else $error("reset request not cleared");
	soft_reset_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		rst_req |=> ##1 o_soft_reset) else $error("soft reset not driven");
	sleep_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		sleep_b && !rst_busy_q |=> o_sleep && !o_accel_sample) else $error("sleep not held");
	no_sample_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		accel_all_off |=> !o_accel_sample) else $error("sample with axes off");
	clk_stop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		code_stop |=> o_timing_rst && !o_use_pll) else $error("clock not stopped");
	int_osc_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		code_int |=> !o_use_pll) else $error("pll used for internal code");
	pll_pick_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!code_int && !code_stop && pll_ok_q |=> o_use_pll) else $error("pll not used");
	port_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_port && !rst_busy_q && i_wdata[PCM_BIT_TWO_WIRE] |=> ##1 o_spi_only && !o_two_wire_en)
		else $error("two-wire not disabled");
	rsvd_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid |-> !o_rdata[7] || $past(i_addr) == PCM_ADDR_PWR_PRIMARY)
		else $error("reserved bit read as one");
	rate_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		idle_b && !sleep_b && !cyc_on |=> o_rate_sense_en == 3'h0 && o_rate_drive_en)
		else $error("rate idle wrong");
	// Awake accel enables follow the standby bits one cycle later
	axis_stby_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!sleep_b |=> o_accel_en == ~$past(axis_q[5:3])) else $error("accel enable wrong");
	// Thermal off bit turns the temperature sensor off
	thermal_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		prim_q[PCM_BIT_THERM_OFF] |=> !o_thermal_en) else $error("thermal sensor not off");
endmodule : pcm_ctrl

//--- pkg/pcm_pkg.sv
// Constants for the power and clock mode control block.
// Assumes a byte-wide register port driven by the serial host interface logic.
// What this block does
// - Reset request returns all registers to defaults
// - Reset request bit self-clears after reset
// - Sleep bit holds device asleep, sensing suspended
// - Cycle mode alternates sleep and one accel sample
// - Cycle wakes without sampling when accel axes standby
// - Rate idle keeps drive, PLL; sense paths off
// - Thermal off bit disables temperature sensor
// - Codes 0 and 6 select internal oscillator
// - Codes 1 to 5 use PLL if ready
// - Code 7 stops clock, holds timing reset
// - Timing source code resets to 001
// - Accel axis standby bit disables that axis
// - Rate axis standby bit disables that axis
// - Two-wire port off leaves SPI-only interface
// - Divider change applies within one old sample period
package pcm_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [6:0] PCM_ADDR_PWR_PRIMARY = 7'h6B;
	localparam logic [6:0] PCM_ADDR_AXIS_STBY   = 7'h6C;
	localparam logic [6:0] PCM_ADDR_HOST_PORT   = 7'h70;
	// ==========================================================
	// Field positions
	localparam int PCM_BIT_RESET_REQ  = 7;
	localparam int PCM_BIT_SLEEP      = 6;
	localparam int PCM_BIT_CYCLE      = 5;
	localparam int PCM_BIT_RATE_IDLE  = 4;
	localparam int PCM_BIT_THERM_OFF  = 3;
	localparam int PCM_BIT_TWO_WIRE   = 6;
	// ==========================================================
	// Writable masks and reset values
	localparam logic [7:0] PCM_MASK_PRIMARY   = 8'h7F;
	localparam logic [7:0] PCM_MASK_AXIS      = 8'h3F;
	localparam logic [7:0] PCM_MASK_HOST_PORT = 8'h40;
	localparam logic [7:0] PCM_RST_PRIMARY    = 8'h01;
	localparam logic [7:0] PCM_RST_AXIS       = 8'h00;
	localparam logic [7:0] PCM_RST_HOST_PORT  = 8'h00;
	// ==========================================================
	// Timing source codes
	localparam logic [2:0] PCM_CLK_INT0 = 3'h0;
	localparam logic [2:0] PCM_CLK_INT6 = 3'h6;
	localparam logic [2:0] PCM_CLK_STOP = 3'h7;
	// ==========================================================
	// Cycle mode sequencer states
	typedef enum logic [1:0] {
		PCM_ST_OFF   = 2'b00,
		PCM_ST_DOZE  = 2'b01,
		PCM_ST_WAKE  = 2'b10
	} pcm_state_t;
	// Base sample interval: 1 kHz from 20 MHz
	localparam int         PCM_BASE_NS      = 1000000;
	localparam int         PCM_CLK_NS       = 50;
	localparam logic [15:0] PCM_BASE_CYCLES = 16'(PCM_BASE_NS / PCM_CLK_NS);
	// Soft reset duration in clocks
	localparam logic [1:0] PCM_RESET_HOLD   = 2'h3;
endpackage : pcm_pkg

//--- hw/pcm_pace.sv
// Sample interval pacer: one tick per divided base period.
// Assumes the divider value is stable only at period boundaries.
`timescale 1ns/100ps
module pcm_pace
	import pcm_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_run,
	input  wire logic [7:0] i_div,
	output logic            o_tick
);
	// ==========================================================
	// Counters
	logic [15:0] base_q;  // Base period counter
	logic [7:0]  div_q;   // Divided period counter
	logic [7:0]  lat_q;   // Divider latched at boundary
	wire         base_end = (base_q == PCM_BASE_CYCLES - 16'h0001);
	wire         div_end  = base_end && (div_q >= lat_q);

	// Count base periods, reload divider each sample
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || !i_run) begin
			base_q <= 16'h0000;
			div_q  <= 8'h00;
			lat_q  <= i_div;
			o_tick <= 1'b0;
		end else begin
			base_q <= base_end ? 16'h0000 : base_q + 16'h0001;
			o_tick <= div_end;
			if (div_end) begin
				div_q <= 8'h00;
				lat_q <= i_div; // New divider used from next sample
			end else if (base_end) begin
				div_q <= div_q + 8'h01;
			end
		end
	end
endmodule : pcm_pace

//--- verification/pcm_host.sv
// Host model: byte register writes and reads toward the control block.
// Assumes one clock; requests change just after a rising edge.
`timescale 1ns/100ps
module pcm_host
	import pcm_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	output logic [6:0]      o_addr,
	output logic [7:0]      o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	// ====================
	// Idle request lines
	initial begin
		o_addr  = 7'h00;
		o_wdata = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end
	// One write; released address and data are scrambled
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_mclk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask : wr
	// One read; data taken once the valid pulse has settled
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_mclk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1;
		d = (i_rvalid === 1'b1) ? i_rdata : 8'hEE;
	endtask : rd
endmodule : pcm_host

//--- verification/test_power_clock_mode_control.sv
// Self-checking bench for the power and clock mode control registers.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
module test_power_clock_mode_control
	import pcm_pkg::*;
;
	logic       i_mclk, i_rst_n, i_pll_ready, h_wr, h_rd, rv;
	logic [6:0] h_addr;
	logic [7:0] h_wd, rdat, i_sample_div;
	logic       sr, slp, smp, drv, pll, thm, upll, cst, trst, tw, spi;
	logic [2:0] acc, rse;
	int         n_fail, checked, cyc, np, ns, nw, t0, t1;
	pcm_host u_host (.i_mclk(i_mclk), .i_rdata(rdat), .i_rvalid(rv), .o_addr(h_addr),
		.o_wdata(h_wd), .o_wr(h_wr), .o_rd(h_rd));
	pcm_ctrl u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(h_addr), .i_wdata(h_wd),
		.i_wr(h_wr), .i_rd(h_rd), .i_pll_ready(i_pll_ready), .i_sample_div(i_sample_div),
		.o_rdata(rdat), .o_rvalid(rv), .o_soft_reset(sr), .o_sleep(slp),
		.o_accel_sample(smp), .o_accel_en(acc), .o_rate_sense_en(rse),
		.o_rate_drive_en(drv), .o_pll_en(pll), .o_thermal_en(thm), .o_use_pll(upll),
		.o_clk_stop(cst), .o_timing_rst(trst), .o_two_wire_en(tw), .o_spi_only(spi));
	// ====================
	// Clock, 50 ns period
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	// Cycle count and hang limit
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask : rchk
	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : wt
	// Wait for one sample pulse, bounded
	task automatic pulse(output int t);
		int k;
		k = 0;
		while (smp !== 1'b1 && k < 21000) begin
			wt(1);
			k++;
		end
		t = cyc;
		wt(1);
	endtask : pulse
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	// ====================
	// Main sequence
	initial begin
		i_rst_n = 1'b0;
		i_pll_ready = 1'b1;
		i_sample_div = 8'h00;
		cyc = 0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rchk(PCM_ADDR_PWR_PRIMARY, 8'h01);
		rchk(PCM_ADDR_AXIS_STBY, 8'h00);
		rchk(PCM_ADDR_HOST_PORT, 8'h00);
		rchk(7'h6D, 8'h00);
		u_host.wr(PCM_ADDR_HOST_PORT, 8'hFF);
		u_host.wr(PCM_ADDR_AXIS_STBY, 8'hEA);
		rchk(PCM_ADDR_HOST_PORT, 8'h40);
		rchk(PCM_ADDR_AXIS_STBY, 8'h2A);
		chk("two_wire", 8'h00, {7'h00, tw});
		chk("spi_only", 8'h01, {7'h00, spi});
		chk("accel_en", 8'h02, {5'h00, acc});
		chk("rate_en", 8'h05, {5'h00, rse});
		u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'h09);
		wt(3);
		chk("thermal", 8'h00, {7'h00, thm});
		u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'h41);
		wt(3);
		chk("sleep", 8'h01, {7'h00, slp});
		chk("accel_en", 8'h00, {5'h00, acc});
		u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'h11);
		wt(3);
		chk("idle", 8'h06, {5'h00, drv, pll, |rse});
		// Every timing source code, PLL ready
		for (int c = 0; c < 8; c++) begin
			u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'(c));
			wt(6);
			chk("use_pll", {7'h00, c inside {[1:5]}}, {7'h00, upll});
			chk("stop", {6'h00, c == 7, c == 7}, {6'h00, cst, trst});
		end
		@(posedge i_mclk);
		i_pll_ready <= 1'b0;
		u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'h01);
		wt(8);
		chk("use_pll", 8'h00, {7'h00, upll});
		@(posedge i_mclk);
		i_pll_ready <= 1'b1;
		// Soft reset returns every register to its default
		u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'h80);
		wt(1);
		chk("soft_reset", 8'h01, {7'h00, sr});
		wt(6);
		rchk(PCM_ADDR_PWR_PRIMARY, 8'h01);
		rchk(PCM_ADDR_AXIS_STBY, 8'h00);
		rchk(PCM_ADDR_HOST_PORT, 8'h00);
		// Cycle mode pacing at the base period
		u_host.wr(PCM_ADDR_PWR_PRIMARY, 8'h20);
		pulse(t0);
		// Divider change mid-period: current period keeps the old rate
		@(posedge i_mclk);
		i_sample_div <= 8'h01;
		pulse(t1);
		chk("gap", 8'h01, {7'h00, (t1 - t0) == int'(PCM_BASE_CYCLES)});
		wt(50);
		chk("doze", 8'h01, {7'h00, slp});
		// All accel axes off: wakes without samples, now every second base period
		u_host.wr(PCM_ADDR_AXIS_STBY, 8'h38);
		np = 0;
		ns = 0;
		nw = 0;
		repeat (39000) begin
			wt(1);
			np += (smp === 1'b1);
			nw += (slp === 1'b0);
		end
		repeat (1500) begin
			wt(1);
			np += (smp === 1'b1);
			ns += (slp === 1'b0);
		end
		chk("samples", 8'h00, 8'(np));
		chk("early_wakes", 8'h00, 8'(nw));
		chk("wakes", 8'h01, {7'h00, ns != 0});
		end_sim();
	end
endmodule : test_power_clock_mode_control
